//--- spi_slave_select_mode_fault.sv
// Purpose: Select handling, mode fault and control/status of an SPI port
// Assumes: Pins synchronous to sys_clk; slave clock slower than sys_clk/4
// Notes:   Master clock is sys_clk/8 from an enable divider
`timescale 1ns/1ps
module spi_slave_select_mode_fault #(
  parameter int data_w = 8
) (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire spi_ss_pkg::reg_req_s      req,
  output logic [7:0]                     rdata,
  input  wire logic                      global_irq_en,
  input  wire logic                      vector_ack,
  output logic                           port_irq,
  output logic                           irq,
  input  wire logic                      sel_n_i,
  output logic                           sel_n_o,
  output logic                           sel_n_oe,
  input  wire logic                      sclk_i,
  output logic                           sclk_o,
  output logic                           sclk_oe,
  input  wire logic                      dout_i,
  output logic                           dout_o,
  output logic                           dout_oe,
  input  wire logic                      din_i,
  output logic                           din_o,
  output logic                           din_oe
);
  localparam int ev_w_c = spi_ss_pkg::ev_w;

  // Pin naming: dout = master out, din = master in
  logic [7:0]               ctrl_reg, ctrl_next;
  logic                     done_reg, done_next;
  logic                     coll_reg, coll_next;
  logic                     armed_reg, armed_next;
  logic [ev_w_c-1:0]        ist_reg, ist_next;
  logic [ev_w_c-1:0]        imask_reg, imask_next;
  spi_ss_pkg::pin_dir_s     dir_reg, dir_next;
  logic [data_w-1:0]        sh_reg, sh_next;
  logic [data_w-1:0]        rxbuf_reg, rxbuf_next;
  logic [3:0]               cnt_reg, cnt_next;
  logic                     sclk_d_reg, sclk_d_next;
  logic                     sel_d_reg, sel_d_next;
  logic [1:0]               div_reg, div_next;
  logic                     mclk_reg, mclk_next;
  logic                     miso_q_reg, miso_q_next;
  logic [7:0]               rdata_next;
  logic                     port_irq_next, irq_next;
  logic                     sel_o_next, sel_oe_next, sclk_o_next, sclk_oe_next;
  logic                     dout_o_next, dout_oe_next, din_o_next, din_oe_next;
  spi_ss_pkg::shift_state_e st_reg, st_next;

  logic en, master, fault, done_ev, wcol_ev, lsb_first, tick;
  logic lead, trail, samp, setup, sclk_now, rise, fall;
  logic ctrl_wr, data_wr, data_acc, stat_rd;

  function automatic logic [data_w-1:0] shift_in(input logic [data_w-1:0] v, input logic lsbf,
                                                input logic b);
    shift_in = lsbf ? {b, v[data_w-1:1]} : {v[data_w-2:0], b};
  endfunction

  function automatic logic out_bit(input logic [data_w-1:0] v, input logic lsbf);
    out_bit = lsbf ? v[0] : v[data_w-1];
  endfunction

  always_comb begin
    en        = ctrl_reg[spi_ss_pkg::port_en_pos];
    master    = ctrl_reg[spi_ss_pkg::master_sel_pos];
    lsb_first = ctrl_reg[spi_ss_pkg::bit_order_pos];
    ctrl_wr   = req.wr && req.addr == spi_ss_pkg::ctrl_addr;
    data_wr   = req.wr && req.addr == spi_ss_pkg::data_addr;
    data_acc  = (req.wr || req.rd) && req.addr == spi_ss_pkg::data_addr;
    stat_rd   = req.rd && req.addr == spi_ss_pkg::status_addr;
    fault     = en && master && !dir_reg.sel_out && !sel_n_i;
    // Fixed divider: rate select bits are stored but ignored
    tick      = div_reg == 2'h3;
    sclk_now  = master ? mclk_reg : sclk_i;
    rise      = sclk_now && !sclk_d_reg;
    fall      = !sclk_now && sclk_d_reg;
    lead      = ctrl_reg[spi_ss_pkg::idle_level_pos] ? fall : rise;
    trail     = ctrl_reg[spi_ss_pkg::idle_level_pos] ? rise : fall;
    samp      = ctrl_reg[spi_ss_pkg::sample_phase_pos] ? trail : lead;
    setup     = ctrl_reg[spi_ss_pkg::sample_phase_pos] ? lead : trail;
  end

  always_comb begin
    ctrl_next   = ctrl_reg;
    done_next   = done_reg;
    coll_next   = coll_reg;
    armed_next  = armed_reg;
    ist_next    = ist_reg;
    imask_next  = imask_reg;
    dir_next    = dir_reg;
    sh_next     = sh_reg;
    rxbuf_next  = rxbuf_reg;
    cnt_next    = cnt_reg;
    st_next     = st_reg;
    div_next    = div_reg + 2'h1;
    mclk_next   = mclk_reg;
    miso_q_next = miso_q_reg;
    sel_d_next  = sel_n_i;
    sclk_d_next = sclk_now;
    done_ev     = 1'b0;
    wcol_ev     = 1'b0;
    if (ctrl_wr) begin
      ctrl_next = req.wdata;
    end
    if (req.wr && req.addr == spi_ss_pkg::irq_mask_addr) begin
      imask_next = req.wdata[ev_w_c-1:0];
    end
    if (req.wr && req.addr == spi_ss_pkg::pin_dir_addr) begin
      dir_next = req.wdata[3:0];
    end
    case (st_reg)
      spi_ss_pkg::st_idle: begin
        mclk_next = ctrl_reg[spi_ss_pkg::idle_level_pos];
        cnt_next  = 4'h0;
        if (data_wr) begin
          sh_next = req.wdata[data_w-1:0];
          if (en && master) begin
            st_next = spi_ss_pkg::st_master;
            div_next = 2'h0;
          end
        end
        if (en && !master && !sel_n_i) begin
          st_next = spi_ss_pkg::st_shift;
          miso_q_next = out_bit(data_wr ? req.wdata[data_w-1:0] : sh_reg, lsb_first);
        end
      end
      spi_ss_pkg::st_shift, spi_ss_pkg::st_master: begin
        // Data write mid-transfer is dropped and flagged
        if (data_wr) begin
          wcol_ev = 1'b1;
        end
        if (st_reg == spi_ss_pkg::st_master && tick) begin
          mclk_next = !mclk_reg;
        end
        if (samp) begin
          sh_next  = shift_in(sh_reg, lsb_first, master ? din_i : dout_i);
          cnt_next = cnt_reg + 4'h1;
        end
        if (setup) begin
          miso_q_next = out_bit(sh_reg, lsb_first);
        end
        if (cnt_reg == spi_ss_pkg::bit_count_last && (setup || !ctrl_reg[spi_ss_pkg::sample_phase_pos])) begin
          rxbuf_next = sh_reg;
          done_ev    = 1'b1;
          cnt_next   = 4'h0;
          if (master) begin
            st_next   = spi_ss_pkg::st_idle;
          end
        end
        // Level, not edge: a deselect in any cycle but the one that completes the byte aborts it
        if (!master && sel_n_i) begin
          st_next  = spi_ss_pkg::st_idle;
          cnt_next = 4'h0;
          sh_next  = '0;
        end
        if (!en || (st_reg == spi_ss_pkg::st_master && !master)) begin
          st_next = spi_ss_pkg::st_idle;
        end
      end
      default: st_next = spi_ss_pkg::st_idle;
    endcase
    // Fault beats a same-cycle control write: contention comes first
    if (fault) begin
      ctrl_next[spi_ss_pkg::master_sel_pos] = 1'b0;
      st_next = spi_ss_pkg::st_idle;
    end
    // Clear sequence: status read with flag set arms, data access clears
    if (stat_rd) begin
      armed_next = done_reg || coll_reg;
    end else if (data_acc && armed_reg) begin
      armed_next = 1'b0;
      done_next  = 1'b0;
      coll_next  = 1'b0;
    end
    if (vector_ack) begin
      done_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (wcol_ev) begin
      coll_next = 1'b1;
    end
    if (done_ev || fault) begin
      done_next = 1'b1;
    end
    if (req.wr && req.addr == spi_ss_pkg::irq_stat_addr) begin
      ist_next = ist_reg & ~req.wdata[ev_w_c-1:0];
    end
    ist_next[spi_ss_pkg::ev_done_pos]  = ist_next[spi_ss_pkg::ev_done_pos] | done_ev;
    ist_next[spi_ss_pkg::ev_fault_pos] = ist_next[spi_ss_pkg::ev_fault_pos] | fault;
  end

  always_comb begin
    rdata_next = 8'h00;
    if (req.rd) begin
      case (req.addr)
        spi_ss_pkg::ctrl_addr:     rdata_next = ctrl_reg;
        spi_ss_pkg::status_addr:   rdata_next = {done_reg, coll_reg, 6'h00};
        spi_ss_pkg::data_addr:     rdata_next = rxbuf_reg;
        spi_ss_pkg::irq_stat_addr: rdata_next = {6'h00, ist_reg};
        spi_ss_pkg::irq_mask_addr: rdata_next = {6'h00, imask_reg};
        spi_ss_pkg::pin_dir_addr:  rdata_next = {4'h0, dir_reg};
        default:                   rdata_next = 8'h00;
      endcase
    end
    port_irq_next = ctrl_next[spi_ss_pkg::irq_en_pos] && done_next && global_irq_en;
    irq_next      = |(ist_next & imask_next);
    // Pin directions follow the mode after this cycle's fault
    sel_o_next   = 1'b1;
    sel_oe_next  = !ctrl_next[spi_ss_pkg::port_en_pos] || ctrl_next[spi_ss_pkg::master_sel_pos] ? dir_next.sel_out : 1'b0;
    sclk_o_next  = mclk_next;
    dout_o_next  = out_bit(sh_next, lsb_first);
    din_o_next   = miso_q_next;
    if (ctrl_next[spi_ss_pkg::port_en_pos] && ctrl_next[spi_ss_pkg::master_sel_pos]) begin
      sclk_oe_next = dir_next.sclk_out;
      dout_oe_next = dir_next.dout_out;
      din_oe_next  = 1'b0;
    end else if (ctrl_next[spi_ss_pkg::port_en_pos]) begin
      sclk_oe_next = 1'b0;
      dout_oe_next = 1'b0;
      din_oe_next  = dir_next.din_out && !sel_n_i;
    end else begin
      sclk_oe_next = 1'b0;
      dout_oe_next = 1'b0;
      din_oe_next  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg   <= spi_ss_pkg::ctrl_reset;
      done_reg   <= 1'b0;
      coll_reg   <= 1'b0;
      armed_reg  <= 1'b0;
      ist_reg    <= '0;
      imask_reg  <= '0;
      dir_reg    <= '0;
      sh_reg     <= '0;
      rxbuf_reg  <= '0;
      cnt_reg    <= 4'h0;
      st_reg     <= spi_ss_pkg::st_idle;
      div_reg    <= 2'h0;
      mclk_reg   <= 1'b0;
      miso_q_reg <= 1'b0;
      sel_d_reg  <= 1'b1;
      sclk_d_reg <= 1'b0;
      rdata      <= 8'h00;
      port_irq   <= 1'b0;
      irq        <= 1'b0;
      sel_n_o    <= 1'b1;
      sel_n_oe   <= 1'b0;
      sclk_o     <= 1'b0;
      sclk_oe    <= 1'b0;
      dout_o     <= 1'b0;
      dout_oe    <= 1'b0;
      din_o      <= 1'b0;
      din_oe     <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      done_reg   <= done_next;
      coll_reg   <= coll_next;
      armed_reg  <= armed_next;
      ist_reg    <= ist_next;
      imask_reg  <= imask_next;
      dir_reg    <= dir_next;
      sh_reg     <= sh_next;
      rxbuf_reg  <= rxbuf_next;
      cnt_reg    <= cnt_next;
      st_reg     <= st_next;
      div_reg    <= div_next;
      mclk_reg   <= mclk_next;
      miso_q_reg <= miso_q_next;
      sel_d_reg  <= sel_d_next;
      sclk_d_reg <= sclk_d_next;
      rdata      <= rdata_next;
      port_irq   <= port_irq_next;
      irq        <= irq_next;
      sel_n_o    <= sel_o_next;
      sel_n_oe   <= sel_oe_next;
      sclk_o     <= sclk_o_next;
      sclk_oe    <= sclk_oe_next;
      dout_o     <= dout_o_next;
      dout_oe    <= dout_oe_next;
      din_o      <= din_o_next;
      din_oe     <= din_oe_next;
    end
  end
endmodule

//--- spi_ss_pkg.sv
// Purpose: Shared constants and types for the SPI select and mode-fault block
// Assumes: 8-bit registers on a plain strobe port
// Notes:   Offsets are register indices on the local port
package spi_ss_pkg;
  localparam logic [2:0] ctrl_addr    = 3'h0;
  localparam logic [2:0] status_addr  = 3'h1;
  localparam logic [2:0] data_addr    = 3'h2;
  localparam logic [2:0] irq_stat_addr = 3'h3;
  localparam logic [2:0] irq_mask_addr = 3'h4;
  localparam logic [2:0] pin_dir_addr  = 3'h5;

  localparam int irq_en_pos      = 7;
  localparam int port_en_pos     = 6;
  localparam int bit_order_pos   = 5;
  localparam int master_sel_pos  = 4;
  localparam int idle_level_pos  = 3;
  localparam int sample_phase_pos = 2;
  localparam int done_flag_pos   = 7;
  localparam int collide_pos     = 6;

  localparam int ev_done_pos     = 0;
  localparam int ev_fault_pos    = 1;
  localparam int ev_w           = 2;

  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [3:0] bit_count_last = 4'h8;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  // Direction of the port pins as software configures them
  typedef struct packed {
    logic dout_out;
    logic sclk_out;
    logic sel_out;
    logic din_out;
  } pin_dir_s;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_shift  = 3'b010,
    st_master = 3'b100
  } shift_state_e;
endpackage

//--- spi_ss_sva.sv
// Purpose: Port assertions for select handling and mode fault
// Assumes: Control and pin direction change only by register writes or fault
// Notes:   Shadows mirror the fault clear of the master bit
`timescale 1ns/1ps
module spi_ss_sva (
  input logic                 sys_clk,
  input logic                 srst,
  input spi_ss_pkg::reg_req_s req,
  input logic [7:0]           rdata,
  input logic                 global_irq_en,
  input logic                 vector_ack,
  input logic                 port_irq,
  input logic                 sel_n_i,
  input logic                 sclk_oe,
  input logic                 dout_oe,
  input logic                 din_oe
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [3:0] dir_reg;
  logic [3:0] dir_next;
  logic       fault;
  logic       slave_on;
  assign fault    = ctrl_reg[6] && ctrl_reg[4] && !dir_reg[1] && !sel_n_i;
  assign slave_on = ctrl_reg[6] && !ctrl_reg[4];
  always_comb begin
    ctrl_next = ctrl_reg;
    dir_next  = dir_reg;
    if (req.wr && req.addr == spi_ss_pkg::ctrl_addr) ctrl_next = req.wdata;
    // The fault beats a rewrite in the same cycle
    if (fault) ctrl_next[4] = 1'b0;
    if (req.wr && req.addr == spi_ss_pkg::pin_dir_addr) dir_next = req.wdata[3:0];
  end
  always_ff @(posedge sys_clk) begin
    ctrl_reg <= srst ? 8'h00 : ctrl_next;
    dir_reg  <= srst ? 4'h0 : dir_next;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_slave_low;
    slave_on && !sel_n_i ##1 slave_on && !sel_n_i && $stable(dir_reg);
  endsequence
  sequence s_slave_high;
    slave_on && sel_n_i ##1 slave_on && sel_n_i;
  endsequence
  sequence s_quiet;
    sel_n_i && !ctrl_reg[4];
  endsequence
  chk_fault_drops_pins: assert property (fault |=> !sclk_oe && !dout_oe)
    else $error("fault left master pins driven");
  chk_fault_raises_irq: assert property (fault && ctrl_next[7] && global_irq_en |=> port_irq)
    else $error("fault did not raise port interrupt");
  chk_irq_gated: assert property (!ctrl_next[7] || !global_irq_en |=> !port_irq)
    else $error("port interrupt without both enables");
  chk_master_held: assert property (!ctrl_reg[4] ##1 !ctrl_reg[4] |-> !sclk_oe)
    else $error("clock driven while master bit clear");
  chk_slave_out_dir: assert property (s_slave_low |-> din_oe == dir_reg[0] && !sclk_oe && !dout_oe)
    else $error("slave pin directions wrong while selected");
  chk_slave_idle_in: assert property (s_slave_high |-> !din_oe && !sclk_oe && !dout_oe)
    else $error("slave drives a pin while deselected");
  chk_ctrl_readback: assert property ($past(req.rd && req.addr == spi_ss_pkg::ctrl_addr) |-> rdata == $past(ctrl_reg))
    else $error("control readback wrong");
  chk_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_vector_clears: assert property (vector_ack ##0 s_quiet ##1 s_quiet |=> !port_irq)
    else $error("vector did not clear done flag");
endmodule

bind spi_slave_select_mode_fault spi_ss_sva u_sva (.sys_clk(sys_clk), .srst(srst), .req(req), .rdata(rdata),
  .global_irq_en(global_irq_en), .vector_ack(vector_ack), .port_irq(port_irq), .sel_n_i(sel_n_i),
  .sclk_oe(sclk_oe), .dout_oe(dout_oe), .din_oe(din_oe));

//--- spi_far_master.sv
// Purpose: Far SPI master driving select, clock and data into the port
// Assumes: Mode 0, most significant bit first
// Notes:   Clock rests low between frames; idle data toggles each cycle
`timescale 1ns/1ps
module spi_far_master (
  input  logic sys_clk,
  output logic sel_n,
  output logic sclk,
  output logic mosi
);
  logic framed;
  initial begin
    sel_n  = 1'b1;
    sclk   = 1'b0;
    mosi   = 1'b0;
    framed = 1'b0;
  end
  // Undriven data must never look like a stable bit
  always @(posedge sys_clk) if (!framed) mosi <= ~mosi;
  task select();
    @(posedge sys_clk);
    sel_n  <= 1'b0;
    framed <= 1'b1;
  endtask
  task deselect();
    @(posedge sys_clk);
    sel_n  <= 1'b1;
    framed <= 1'b0;
  endtask
  // Half period hp stays above two system clocks
  task shift(input int n, input logic [7:0] d, input int hp);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      mosi <= d[7-i];
      repeat (hp) @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (hp) @(posedge sys_clk);
      sclk <= 1'b0;
    end
  endtask
endmodule

//--- tb.sv
// Purpose: Register-level tests of select handling and mode fault
// Assumes: Far master model on the serial pins
// Notes:   Pin levels resolve from the port's output enables alone
`timescale 1ns/1ps
module tb;
  logic                 sys_clk, srst, gie, vector_ack, port_irq, irq, din_idle, din_fixed;
  spi_ss_pkg::reg_req_s req;
  logic [7:0]           rdata;
  logic                 sel_n_i, sel_n_o, sel_n_oe, sclk_i, sclk_o, sclk_oe;
  logic                 dout_i, dout_o, dout_oe, din_i, din_o, din_oe, f_sel, f_sclk, f_mosi;
  int                   miscompares, cmp_count;
  assign sel_n_i = sel_n_oe ? sel_n_o : f_sel;
  assign sclk_i  = sclk_oe ? sclk_o : f_sclk;
  assign dout_i  = dout_oe ? dout_o : f_mosi;
  assign din_i   = din_oe ? din_o : din_idle;
  spi_far_master far (.sys_clk(sys_clk), .sel_n(f_sel), .sclk(f_sclk), .mosi(f_mosi));
  spi_slave_select_mode_fault #(.data_w(8)) uut (.sys_clk(sys_clk), .srst(srst), .req(req), .rdata(rdata),
    .global_irq_en(gie), .vector_ack(vector_ack), .port_irq(port_irq), .irq(irq), .sel_n_i(sel_n_i),
    .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe), .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .dout_i(dout_i), .dout_o(dout_o), .dout_oe(dout_oe), .din_i(din_i), .din_o(din_o), .din_oe(din_oe));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Released line toggles; held high for the master transfer test
  always @(posedge sys_clk) din_idle <= din_fixed | ~din_idle;
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req <= '0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req <= '0;
    #1 chk8(rdata, exp);
  endtask
  task settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task stop_test();
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    srst = 1'b1;
    req = '0;
    gie = 1'b0;
    vector_ack = 1'b0;
    din_idle = 1'b0;
    din_fixed = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    rd(spi_ss_pkg::ctrl_addr, 8'h00);
    rd(spi_ss_pkg::status_addr, 8'h00);
    rd(3'h7, 8'h00);
    wr(spi_ss_pkg::ctrl_addr, 8'h63);
    rd(spi_ss_pkg::ctrl_addr, 8'h63);
    wr(spi_ss_pkg::pin_dir_addr, 8'h01);
    wr(spi_ss_pkg::ctrl_addr, 8'h40);
    wr(spi_ss_pkg::data_addr, 8'h80);
    far.select();
    settle();
    chk1(din_oe, 1'b1);
    chk1(din_o, 1'b1);
    far.shift(3, 8'ha5, 4);
    far.deselect();
    settle();
    chk1(din_oe, 1'b0);
    rd(spi_ss_pkg::status_addr, 8'h00);
    far.select();
    far.shift(8, 8'h3c, 6);
    far.deselect();
    rd(spi_ss_pkg::status_addr, 8'h80);
    rd(spi_ss_pkg::data_addr, 8'h3c);
    rd(spi_ss_pkg::status_addr, 8'h00);
    // Least significant bit first: far master sends msb first, so bits arrive reversed
    wr(spi_ss_pkg::ctrl_addr, 8'h60);
    far.select();
    far.shift(8, 8'hc1, 6);
    far.deselect();
    rd(spi_ss_pkg::status_addr, 8'h80);
    rd(spi_ss_pkg::data_addr, 8'h83);
    rd(spi_ss_pkg::status_addr, 8'h00);
    wr(spi_ss_pkg::irq_stat_addr, 8'h03);
    wr(spi_ss_pkg::irq_mask_addr, 8'h02);
    wr(spi_ss_pkg::pin_dir_addr, 8'h0c);
    gie <= 1'b1;
    wr(spi_ss_pkg::ctrl_addr, 8'hd3);
    settle();
    chk1(sclk_oe, 1'b1);
    chk1(sel_n_oe, 1'b0);
    chk1(sel_n_o, 1'b1);
    far.select();
    settle();
    chk1(sclk_oe, 1'b0);
    chk1(dout_oe, 1'b0);
    chk1(port_irq, 1'b1);
    chk1(irq, 1'b1);
    far.deselect();
    settle();
    chk1(sclk_oe, 1'b0);
    rd(spi_ss_pkg::ctrl_addr, 8'hc3);
    rd(spi_ss_pkg::irq_stat_addr, 8'h02);
    wr(spi_ss_pkg::irq_stat_addr, 8'h02);
    settle();
    chk1(irq, 1'b0);
    @(posedge sys_clk);
    vector_ack <= 1'b1;
    @(posedge sys_clk);
    vector_ack <= 1'b0;
    settle();
    chk1(port_irq, 1'b0);
    rd(spi_ss_pkg::status_addr, 8'h00);
    wr(spi_ss_pkg::ctrl_addr, 8'hd3);
    settle();
    chk1(sclk_oe, 1'b1);
    gie <= 1'b0;
    far.select();
    settle();
    chk1(port_irq, 1'b0);
    chk1(irq, 1'b1);
    far.deselect();
    rd(spi_ss_pkg::status_addr, 8'h80);
    rd(spi_ss_pkg::data_addr, 8'h83);
    // Master transfer with din held high; the second data write collides
    din_fixed <= 1'b1;
    wr(spi_ss_pkg::ctrl_addr, 8'hd3);
    wr(spi_ss_pkg::data_addr, 8'h5a);
    wr(spi_ss_pkg::data_addr, 8'h77);
    repeat (80) @(posedge sys_clk);
    rd(spi_ss_pkg::status_addr, 8'hc0);
    rd(spi_ss_pkg::data_addr, 8'hff);
    rd(spi_ss_pkg::status_addr, 8'h00);
    settle();
    chk1(sclk_o, 1'b0);
    chk1(dout_o, 1'b1);
    stop_test();
  end
endmodule
